// ### pmb_consts.svh
// Constants for the processor mode and external bus configuration block.
`ifndef PMB_CONSTS_SVH
`define PMB_CONSTS_SVH
`define PMB_MODE_SINGLE 2'h0
`define PMB_MODE_EXPAND 2'h1
`define PMB_MODE_BAD 2'h2
`define PMB_MODE_MICRO 2'h3
`define PMB_BUS_ALLMUX 2'h3
`define PMB_AW_LO 1'h0
`define PMB_AW_HI 1'h1
`define PMB_NUM_CS 4
`define PMB_WAIT_ONE 3'h1
`define PMB_WAIT_ZERO 3'h0
`define PMB_CS_LIMIT_MASK 20'h000FF
`define PMB_ADDR_MASK_12 20'h00FFF
`define PMB_ADDR_MASK_16 20'h0FFFF
`define PMB_ADDR_MASK_20 20'hFFFFF
`define PMB_UPPER_RESET 6'h00
`define PMB_CSEN_RESET 4'h1
`define PMB_CSW_RESET 4'h0
`define PMB_CSE_RESET 8'h00
`endif

// ### pmb_pkg.sv
// Types for the processor mode and external bus configuration block.
package pmb_pkg;
    typedef enum logic [1:0] {
        PMB_ST_RESET = 2'h0,
        PMB_ST_RUN = 2'h1,
        PMB_ST_HOLD = 2'h3
    } pmb_state_t;
    typedef struct packed {
        pmb_state_t state;
        logic [1:0] procMode;
        logic [5:0] upperBits;
        logic addrWidthLoSel;
        logic wdtResetSelect;
        logic globalWaitBit;
        logic [3:0] csEnable;
        logic [3:0] areaWaitDisable;
        logic [7:0] areaWaitCount;
        logic romBlocked;
        logic addrValid;
    } pmb_regs_t;
endpackage : pmb_pkg

// ### pmb_wait_calc.sv
// Wait-state calculator for one chip-select area.
`include "pmb_consts.svh"
module pmb_wait_calc (
    input wire logic globalWait,
    input wire logic waitDisable,
    input wire logic [1:0] waitCount,
    output logic [2:0] waits
);
    // Wait disable cleared uses the per-area count, at least one cycle.
    always_comb begin
        if (!waitDisable) begin
            waits = `PMB_WAIT_ONE + {1'b0, waitCount};
        end else if (globalWait) begin
            waits = `PMB_WAIT_ONE;
        end else begin
            waits = `PMB_WAIT_ZERO;
        end
    end
endmodule : pmb_wait_calc

// ### pmb_mode_cfg.sv
// Processor mode selection and external bus configuration registers.
//
// Contract
// - Mode field 00 single-chip, 01 expansion, 11 microprocessor; 10 is prohibited.
// - Hardware reset enters single-chip with strap low, microprocessor with strap high.
// - Writing the mode field sets the mode regardless of the strap level.
// - Hardware reset with strap high blocks internal ROM access until a hardware reset with strap low.
// - Mode field survives software, watchdog and oscillation-stop resets.
// - Mode registers are written only while the protect unlock bit is set.
// - Bus mode 11 in expansion frees upper address pins; areas become 256 bytes.
// - Watchdog reset select is set-only; writing zero has no effect.
// - Global wait bit adds one wait to internal RAM and ROM access and to areas with wait disable set.
// - Area wait disable cleared forces at least one wait for that area.
// - Global wait gives chip-select areas one wait even when wait disable is set.
// - With wait disable cleared, a two-bit per-area count selects wait cycles.
// - Bus mode field selects separate or multiplexed bus.
// - Multiplexed 8-bit bus carries address bits 0 to 7 on data lines 0 to 7.
// - Multiplexed 16-bit bus carries address bits 1 to 8; only even addresses.
// - Width bits select 12, 16 or 20 address bits; unused pins among address bits 16 to 19 become ports.
// - After entering expansion mode the address is undefined until an external access.
// - Width pin high gives eight data lines, low gives sixteen.
// - Four chip-select pins are each a port or chip select by enable bit.
`include "pmb_consts.svh"
module pmb_mode_cfg (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic sysReset,
    input wire logic modeStrapPin,
    input wire logic byteWidthPin,
    input wire logic protectUnlockBit,
    input wire logic wrMode0,
    input wire logic [1:0] wrProcModeField,
    input wire logic [5:0] wrUpperModeBits,
    input wire logic wrMode1,
    input wire logic wrAddrWidthLoSel,
    input wire logic wrWdtResetSelect,
    input wire logic wrGlobalWaitBit,
    input wire logic wrChipSelect,
    input wire logic [3:0] wrCsEnable,
    input wire logic [3:0] wrAreaWaitDisable,
    input wire logic wrWaitExt,
    input wire logic [7:0] wrAreaWaitCount,
    input wire logic extAccess,
    input wire logic [1:0] extArea,
    input wire logic [19:0] cpuAddr,
    output logic [1:0] procModeField,
    output logic [5:0] upperModeBits,
    output logic singleChipMode,
    output logic memExpansionMode,
    output logic microprocessorMode,
    output logic romAccessEnable,
    output logic multiplexedBus,
    output logic [1:0] addrWidthCode,
    output logic [3:0] upperAddrPortSel,
    output logic [6:0] p3p4PortSel,
    output logic wideDataBus,
    output logic [3:0] chipSelectOut,
    output logic [19:0] extAddrOut,
    output logic extAddrValid,
    output logic [7:0] muxAddrOut,
    output logic wdtResetSelect,
    output logic globalWaitBit,
    output logic [2:0] internalWaits,
    output logic [2:0] areaWaits
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pmb_pkg::pmb_regs_t regsFf;
    pmb_pkg::pmb_regs_t nxtRegs;
    logic [2:0] areaWaitVec [`PMB_NUM_CS];
    logic [1:0] busModeField;
    logic expandMode;
    logic allMux;
    logic [19:0] addrMask;

    // Decodes whether a mode field value drives the external bus.
    function automatic logic pmb_is_external(input logic [1:0] mode);
        pmb_is_external = (mode == `PMB_MODE_EXPAND) || (mode == `PMB_MODE_MICRO);
    endfunction : pmb_is_external

    // Mask of address bits that leave the chip for the given width bits.
    function automatic logic [19:0] pmb_addr_mask(input logic hi, input logic lo);
        if (hi && lo) begin
            pmb_addr_mask = `PMB_ADDR_MASK_12;
        end else if (hi) begin
            pmb_addr_mask = `PMB_ADDR_MASK_16;
        end else begin
            pmb_addr_mask = `PMB_ADDR_MASK_20;
        end
    endfunction : pmb_addr_mask

    // Bus mode and width selection decoded from the stored bits.
    assign busModeField = regsFf.upperBits[3:2];
    assign expandMode = regsFf.procMode == `PMB_MODE_EXPAND;
    assign allMux = expandMode && (busModeField == `PMB_BUS_ALLMUX);
    assign addrMask = pmb_addr_mask(regsFf.upperBits[4], regsFf.addrWidthLoSel);

    // ------------------------------------------------------------
    // Per-area wait calculators
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PMB_NUM_CS; gi++) begin : g_wait
            pmb_wait_calc u_wait (
                .globalWait(regsFf.globalWaitBit),
                .waitDisable(regsFf.areaWaitDisable[gi]),
                .waitCount(regsFf.areaWaitCount[2*gi+:2]),
                .waits(areaWaitVec[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Mode register writes gated by the unlock bit; the mode survives system resets.
    always_comb begin
        nxtRegs = regsFf;
        if (regsFf.state == pmb_pkg::PMB_ST_RESET) begin
            // Strap is caught on the first clocked cycle after reset release.
            nxtRegs.procMode = modeStrapPin ? `PMB_MODE_MICRO : `PMB_MODE_SINGLE;
            nxtRegs.romBlocked = modeStrapPin;
            nxtRegs.state = pmb_pkg::PMB_ST_RUN;
        end else if (sysReset) begin
            // Soft, watchdog and oscillation resets keep mode and ROM block.
            nxtRegs.upperBits = `PMB_UPPER_RESET;
            nxtRegs.addrWidthLoSel = `PMB_AW_LO;
            nxtRegs.globalWaitBit = 1'b0;
            nxtRegs.csEnable = `PMB_CSEN_RESET;
            nxtRegs.areaWaitDisable = `PMB_CSW_RESET;
            nxtRegs.areaWaitCount = `PMB_CSE_RESET;
            nxtRegs.addrValid = 1'b0;
        end else begin
            if (wrMode0 && protectUnlockBit) begin
                if (wrProcModeField != `PMB_MODE_BAD) begin
                    nxtRegs.procMode = wrProcModeField;
                end
                nxtRegs.upperBits = wrUpperModeBits;
                if (!pmb_is_external(regsFf.procMode)
                        && pmb_is_external(wrProcModeField)) begin
                    nxtRegs.addrValid = 1'b0;
                end
            end
            if (wrMode1 && protectUnlockBit) begin
                nxtRegs.addrWidthLoSel = wrAddrWidthLoSel;
                nxtRegs.wdtResetSelect = regsFf.wdtResetSelect | wrWdtResetSelect;
                nxtRegs.globalWaitBit = wrGlobalWaitBit;
            end
            if (wrChipSelect) begin
                nxtRegs.csEnable = wrCsEnable;
                nxtRegs.areaWaitDisable = wrAreaWaitDisable;
            end
            if (wrWaitExt) begin
                nxtRegs.areaWaitCount = wrAreaWaitCount;
            end
            if (extAccess && pmb_is_external(regsFf.procMode)) begin
                nxtRegs.addrValid = 1'b1;
            end
        end
    end

    // Registers the state; clock enable low freezes everything.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regsFf.state <= pmb_pkg::PMB_ST_RESET;
            regsFf.procMode <= `PMB_MODE_SINGLE;
            regsFf.upperBits <= `PMB_UPPER_RESET;
            regsFf.addrWidthLoSel <= `PMB_AW_LO;
            regsFf.wdtResetSelect <= 1'b0;
            regsFf.globalWaitBit <= 1'b0;
            regsFf.csEnable <= `PMB_CSEN_RESET;
            regsFf.areaWaitDisable <= `PMB_CSW_RESET;
            regsFf.areaWaitCount <= `PMB_CSE_RESET;
            regsFf.romBlocked <= 1'b0;
            regsFf.addrValid <= 1'b0;
        end else if (clkEn) begin
            regsFf <= nxtRegs;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // All outputs are registered views of the current state and bus inputs; extAddrValid follows the next state.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            procModeField <= `PMB_MODE_SINGLE;
            upperModeBits <= `PMB_UPPER_RESET;
            singleChipMode <= 1'b1;
            memExpansionMode <= 1'b0;
            microprocessorMode <= 1'b0;
            romAccessEnable <= 1'b0;
            multiplexedBus <= 1'b0;
            addrWidthCode <= 2'h0;
            upperAddrPortSel <= 4'h0;
            p3p4PortSel <= 7'h00;
            wideDataBus <= 1'b0;
            chipSelectOut <= 4'hF;
            extAddrOut <= 20'h00000;
            extAddrValid <= 1'b0;
            muxAddrOut <= 8'h00;
            wdtResetSelect <= 1'b0;
            globalWaitBit <= 1'b0;
            internalWaits <= `PMB_WAIT_ZERO;
            areaWaits <= `PMB_WAIT_ZERO;
        end else if (clkEn) begin
            procModeField <= regsFf.procMode;
            upperModeBits <= regsFf.upperBits;
            singleChipMode <= regsFf.procMode == `PMB_MODE_SINGLE;
            memExpansionMode <= expandMode;
            microprocessorMode <= regsFf.procMode == `PMB_MODE_MICRO;
            romAccessEnable <= !regsFf.romBlocked
                && (regsFf.procMode != `PMB_MODE_MICRO);
            multiplexedBus <= busModeField != 2'h0;
            addrWidthCode <= {regsFf.addrWidthLoSel, regsFf.upperBits[4]};
            upperAddrPortSel <= ~addrMask[19:16];
            p3p4PortSel <= allMux ? 7'h7F : 7'h00;
            wideDataBus <= !byteWidthPin;
            // Active-low chip selects only for enabled areas on an external access.
            for (int i = 0; i < `PMB_NUM_CS; i++) begin
                chipSelectOut[i] <= !(regsFf.csEnable[i] && extAccess
                    && (extArea == i[1:0]) && pmb_is_external(regsFf.procMode));
            end
            if (extAccess) begin
                extAddrOut <= cpuAddr & addrMask & (allMux ? `PMB_CS_LIMIT_MASK
                    : `PMB_ADDR_MASK_20);
                muxAddrOut <= byteWidthPin ? cpuAddr[7:0] : cpuAddr[8:1];
            end
            extAddrValid <= nxtRegs.addrValid;
            wdtResetSelect <= regsFf.wdtResetSelect;
            globalWaitBit <= regsFf.globalWaitBit;
            internalWaits <= regsFf.globalWaitBit ? `PMB_WAIT_ONE : `PMB_WAIT_ZERO;
            areaWaits <= areaWaitVec[extArea];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // A stored mode is always one of the three legal codes.
    AST_NO_BAD_MODE: assert property (regsFf.procMode != `PMB_MODE_BAD)
        else $error("Prohibited mode value stored.");

    // The strap decides the mode on the first enabled cycle after reset.
    AST_STRAP_MODE: assert property ((regsFf.state == pmb_pkg::PMB_ST_RESET) && clkEn
        |=> regsFf.procMode == ($past(modeStrapPin) ? `PMB_MODE_MICRO : `PMB_MODE_SINGLE))
        else $error("Mode after reset does not follow strap.");

    // An unlocked legal write lands whatever the strap level is.
    AST_WRITE_MODE: assert property (clkEn && regsFf.state != pmb_pkg::PMB_ST_RESET
        && !sysReset && wrMode0 && protectUnlockBit && wrProcModeField != `PMB_MODE_BAD
        |=> regsFf.procMode == $past(wrProcModeField))
        else $error("Mode write not applied.");

    // Only a hardware reset may lift the ROM block.
    AST_ROM_BLOCK: assert property (regsFf.romBlocked |=> regsFf.romBlocked)
        else $error("ROM block cleared without hardware reset.");

    // System resets leave the mode field alone.
    AST_MODE_KEEP: assert property (sysReset && regsFf.state != pmb_pkg::PMB_ST_RESET
        |=> $stable(regsFf.procMode))
        else $error("Mode changed by system reset.");

    // With the unlock bit low the protected fields hold.
    AST_LOCKED: assert property (!protectUnlockBit && !sysReset
        && regsFf.state != pmb_pkg::PMB_ST_RESET |=> $stable(regsFf.procMode)
        && $stable(regsFf.globalWaitBit))
        else $error("Locked register changed.");

    // Once set, the watchdog select stays set.
    AST_WDT_SET_ONLY: assert property (regsFf.wdtResetSelect && !sysReset
        |=> regsFf.wdtResetSelect)
        else $error("Watchdog select cleared.");

    // The global wait bit gives internal accesses one wait and the selected area at least one.
    AST_GLOBAL_WAIT: assert property (clkEn && regsFf.globalWaitBit
        |=> internalWaits == `PMB_WAIT_ONE ##0 areaWaits != `PMB_WAIT_ZERO)
        else $error("Global wait not applied.");

    // Without the global wait bit internal accesses run without waits.
    AST_NO_GLOBAL_WAIT: assert property (clkEn && !regsFf.globalWaitBit
        |=> internalWaits == `PMB_WAIT_ZERO)
        else $error("Internal wait without global wait bit.");

    // An area with waits enabled never runs at zero waits.
    AST_AREA_WAIT: assert property (clkEn && !regsFf.areaWaitDisable[extArea]
        |=> areaWaits >= `PMB_WAIT_ONE)
        else $error("Area without wait disable ran zero waits.");

    // Byte-wide multiplexed bus carries the low address byte.
    AST_MUX8: assert property (clkEn && extAccess && byteWidthPin
        |=> muxAddrOut == $past(cpuAddr[7:0]))
        else $error("Multiplexed address byte wrong.");

    // Word-wide multiplexed bus carries address bits one to eight.
    AST_MUX16: assert property (clkEn && extAccess && !byteWidthPin
        |=> muxAddrOut == $past(cpuAddr[8:1]))
        else $error("Word multiplexed address wrong.");

    // The bus mode field picks separate or multiplexed bus.
    AST_MUX_BUS: assert property (clkEn
        |=> multiplexedBus == ($past(busModeField) != 2'h0))
        else $error("Bus mode not reflected.");

    // Whole-space multiplexing in expansion mode frees the upper pins.
    AST_BUS_FREE: assert property (clkEn && allMux
        |=> p3p4PortSel == 7'h7F)
        else $error("Upper address pins not freed.");

    // The high width bit turns the top address pins into ports.
    AST_ADDR_PORTS: assert property (clkEn && regsFf.upperBits[4]
        |=> upperAddrPortSel == 4'hF)
        else $error("Top address pins not released.");

    // Data width follows the width pin.
    AST_WIDE: assert property (clkEn
        |=> wideDataBus == !$past(byteWidthPin))
        else $error("Data width does not follow pin.");

    // Chip selects stay high without an external access.
    AST_CS_IDLE: assert property (clkEn && !extAccess
        |=> chipSelectOut == 4'hF)
        else $error("Chip select active without access.");

    // A disabled chip select 0 pin acts as a port and stays high.
    AST_CS_PORT: assert property (clkEn && !regsFf.csEnable[0]
        |=> chipSelectOut[0])
        else $error("Disabled chip select driven low.");

    // Entering an external mode from single-chip drops address validity.
    AST_VALID_CLEAR: assert property (clkEn && !sysReset
        && regsFf.state != pmb_pkg::PMB_ST_RESET && wrMode0 && protectUnlockBit
        && !pmb_is_external(regsFf.procMode) && pmb_is_external(wrProcModeField)
        |=> !regsFf.addrValid)
        else $error("Address valid kept across mode entry.");

    // Main scenarios worth seeing at least once.
    COV_MICRO: cover property (microprocessorMode && !romAccessEnable);
    COV_EXPAND: cover property (memExpansionMode && p3p4PortSel != 7'h00);
    COV_WAIT: cover property (areaWaits == 3'h4);
    COV_AREA3: cover property (areaWaits == 3'h3);
    COV_VALID: cover property (memExpansionMode && extAddrValid);
endmodule : pmb_mode_cfg

// ### pmb_ext_device.sv
// Model of an external memory that sits on the chip-select and address outputs.
module pmb_ext_device (
    input wire logic sys_clk,
    input wire logic [3:0] chipSelectOut,
    input wire logic [19:0] extAddrOut,
    output logic byteWidthPin,
    output logic [7:0] hitCount,
    output logic [19:0] lastAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Width strap and access capture
    // --------------------------------------------------------------
    // The width strap is wired high and never toggles, so the bus stays 8 bits wide.
    assign byteWidthPin = 1'h1;
    initial begin
        hitCount = 8'h00;
        lastAddr = 20'h00000;
    end
    // Any low chip select counts as a selected access and latches the address.
    always @(posedge sys_clk) begin
        if (chipSelectOut !== 4'hF) begin
            hitCount <= hitCount + 8'h01;
            lastAddr <= extAddrOut;
        end
    end
endmodule : pmb_ext_device

// ### pmb_mode_cfg_bench.sv
// Self-checking bench for the processor mode and external bus configuration block.
module pmb_mode_cfg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0, rst = 1'h1, clkEn = 1'h1, sysReset = 1'h0, modeStrapPin = 1'h0;
    logic protectUnlockBit = 1'h1, wrMode0 = 1'h0, wrMode1 = 1'h0, wrChipSelect = 1'h0;
    logic wrWaitExt = 1'h0, wrAddrWidthLoSel = 1'h0, wrWdtResetSelect = 1'h0;
    logic wrGlobalWaitBit = 1'h0, extAccess = 1'h0, byteWidthPin;
    logic [1:0] wrProcModeField = 2'h0, extArea = 2'h0, procModeField, addrWidthCode;
    logic [5:0] wrUpperModeBits = 6'h00, upperModeBits;
    logic [3:0] wrCsEnable = 4'h1, wrAreaWaitDisable = 4'h0, upperAddrPortSel, chipSelectOut;
    logic [7:0] wrAreaWaitCount = 8'h00, muxAddrOut, hitCount;
    logic [19:0] cpuAddr = 20'h00000, extAddrOut, lastAddr;
    logic [6:0] p3p4PortSel;
    logic [2:0] internalWaits, areaWaits;
    logic singleChipMode, memExpansionMode, microprocessorMode, romAccessEnable;
    logic multiplexedBus, wideDataBus, extAddrValid, wdtResetSelect, globalWaitBit;
    int failures = 0;
    int tests_run = 0;
    int m;
    // --------------------------------------------------------------
    // Clock, design and external device
    // --------------------------------------------------------------
    // The clock toggles every 2 ns for a 4 ns period.
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    pmb_mode_cfg pmb_mode_cfg_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .sysReset(sysReset), .modeStrapPin(modeStrapPin), .byteWidthPin(byteWidthPin),
        .protectUnlockBit(protectUnlockBit), .wrMode0(wrMode0),
        .wrProcModeField(wrProcModeField), .wrUpperModeBits(wrUpperModeBits),
        .wrMode1(wrMode1), .wrAddrWidthLoSel(wrAddrWidthLoSel),
        .wrWdtResetSelect(wrWdtResetSelect), .wrGlobalWaitBit(wrGlobalWaitBit),
        .wrChipSelect(wrChipSelect), .wrCsEnable(wrCsEnable),
        .wrAreaWaitDisable(wrAreaWaitDisable), .wrWaitExt(wrWaitExt),
        .wrAreaWaitCount(wrAreaWaitCount), .extAccess(extAccess), .extArea(extArea),
        .cpuAddr(cpuAddr), .procModeField(procModeField), .upperModeBits(upperModeBits),
        .singleChipMode(singleChipMode), .memExpansionMode(memExpansionMode),
        .microprocessorMode(microprocessorMode), .romAccessEnable(romAccessEnable),
        .multiplexedBus(multiplexedBus), .addrWidthCode(addrWidthCode),
        .upperAddrPortSel(upperAddrPortSel), .p3p4PortSel(p3p4PortSel),
        .wideDataBus(wideDataBus), .chipSelectOut(chipSelectOut), .extAddrOut(extAddrOut),
        .extAddrValid(extAddrValid), .muxAddrOut(muxAddrOut),
        .wdtResetSelect(wdtResetSelect), .globalWaitBit(globalWaitBit),
        .internalWaits(internalWaits), .areaWaits(areaWaits));
    pmb_ext_device pmb_ext_device_inst (.sys_clk(sys_clk), .chipSelectOut(chipSelectOut),
        .extAddrOut(extAddrOut), .byteWidthPin(byteWidthPin), .hitCount(hitCount),
        .lastAddr(lastAddr));
    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    // Compares a settled value with the expected one and counts the result.
    task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
        end
    endtask : check
    // Drops the strobes and lets the two-cycle answer settle before sampling.
    task automatic finish_wr();
        @(posedge sys_clk);
        {wrMode0, wrMode1, wrChipSelect, wrWaitExt, sysReset} <= 5'h00;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : finish_wr
    // Holds reset for eight cycles with the given strap level.
    task automatic do_reset(input logic strap);
        @(posedge sys_clk);
        rst <= 1'h1;
        modeStrapPin <= strap;
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : do_reset
    // Writes the mode field and the upper bits of the first mode register.
    task automatic wr0(input logic [1:0] md, input logic [5:0] up);
        @(posedge sys_clk);
        wrMode0 <= 1'h1;
        wrProcModeField <= md;
        wrUpperModeBits <= up;
        finish_wr();
    endtask : wr0
    // Writes the second mode register.
    task automatic wr1(input logic lo, input logic wdt, input logic gw);
        @(posedge sys_clk);
        wrMode1 <= 1'h1;
        {wrAddrWidthLoSel, wrWdtResetSelect, wrGlobalWaitBit} <= {lo, wdt, gw};
        finish_wr();
    endtask : wr1
    // Writes chip-select enables, wait disables and the wait-extension counts.
    task automatic wr_cs(input logic [3:0] en, input logic [3:0] wd, input logic [7:0] cnt);
        @(posedge sys_clk);
        {wrChipSelect, wrWaitExt} <= 2'h3;
        {wrCsEnable, wrAreaWaitDisable, wrAreaWaitCount} <= {en, wd, cnt};
        finish_wr();
    endtask : wr_cs
    // Runs one external access for two cycles.
    task automatic ext_acc(input logic [1:0] area, input logic [19:0] addr);
        @(posedge sys_clk);
        {extAccess, extArea, cpuAddr} <= {1'h1, area, addr};
        repeat (2) @(posedge sys_clk);
        extAccess <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : ext_acc
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    // Each block below is one test; a line is printed as it ends.
    initial begin
        do_reset(1'h0);
        check(singleChipMode, 1'h1, "strap low mode");
        check(chipSelectOut, 4'hF, "idle chip selects");
        check(romAccessEnable, 1'h1, "rom open");
        $display("test reset strap low done");
        for (m = 0; m < 3; m++) begin
            wr0((m == 0) ? 2'h1 : (m == 1) ? 2'h3 : 2'h0, 6'h00);
            check(procModeField, (m == 0) ? 2'h1 : (m == 1) ? 2'h3 : 2'h0, "field");
            check({singleChipMode, memExpansionMode, microprocessorMode},
                (m == 0) ? 3'h2 : (m == 1) ? 3'h1 : 3'h4, "mode flags");
        end
        wr0(2'h1, 6'h00);
        wr0(2'h2, 6'h00);
        check(procModeField, 2'h1, "prohibited code");
        protectUnlockBit <= 1'h0;
        wr0(2'h3, 6'h00);
        check(procModeField, 2'h1, "locked write");
        protectUnlockBit <= 1'h1;
        @(posedge sys_clk);
        sysReset <= 1'h1;
        finish_wr();
        check(memExpansionMode, 1'h1, "mode after soft reset");
        $display("test mode writes done");
        wr1(1'h0, 1'h1, 1'h0);
        wr1(1'h0, 1'h0, 1'h0);
        check(wdtResetSelect, 1'h1, "set-only select");
        ext_acc(2'h0, 20'h01234);
        check(extAddrValid, 1'h1, "address valid");
        check(extAddrOut, 20'h01234, "address out");
        check(hitCount > 8'h00, 1'h1, "device selected");
        check(lastAddr, 20'h01234, "device address");
        $display("test external access done");
        wr_cs(4'h3, 4'h0, 8'h08);
        extArea <= 2'h1;
        @(posedge sys_clk);
        #1;
        check(areaWaits, 3'h3, "extended waits");
        wr_cs(4'h3, 4'hF, 8'h08);
        check(areaWaits, 3'h0, "no waits");
        wr1(1'h0, 1'h0, 1'h1);
        check(areaWaits, 3'h1, "global wait area");
        check(internalWaits, 3'h1, "global wait internal");
        check(globalWaitBit, 1'h1, "global wait flag");
        $display("test waits done");
        wr0(2'h0, 6'h0C);
        wr0(2'h1, 6'h0C);
        check(upperModeBits, 6'h0C, "upper bits");
        check(multiplexedBus, 1'h1, "multiplexed");
        check(p3p4PortSel, 7'h7F, "freed pins");
        check(wideDataBus, 1'h0, "byte bus");
        ext_acc(2'h0, 20'h123A5);
        check(muxAddrOut, 8'hA5, "mux address");
        check(extAddrOut, 20'h000A5, "256 byte area");
        wr0(2'h0, 6'h10);
        wr1(1'h1, 1'h0, 1'h0);
        check(addrWidthCode, 2'h3, "12 bit width");
        check(upperAddrPortSel, 4'hF, "address pins as ports");
        $display("test bus setup done");
        do_reset(1'h1);
        check(microprocessorMode, 1'h1, "strap high mode");
        check(romAccessEnable, 1'h0, "rom blocked");
        wr0(2'h0, 6'h00);
        check({singleChipMode, romAccessEnable}, 2'h2, "rom stays blocked");
        $display("test strap high done");
        give_verdict();
    end
endmodule : pmb_mode_cfg_bench
